/* File: rtl/rts_pkg.sv */
package rts_pkg;
  // number of test-point pins
  localparam int TP_WIDTH = 8;
  // reset values of the pin and selection state
  localparam logic [7:0] TP_OE_N_RST = 8'hff;
  localparam logic [7:0] TP_OUT_RST = 8'h00;
  localparam logic [7:0] TEST_SEL_RST = 8'h00;
  // clock rate and the strap sampling delay after reset release
  localparam int CLK_MHZ = 100;
  localparam int SAMPLE_DELAY_NS = 1500;
  // delay is approximate, so whole cycles rounded down
  localparam int SAMPLE_CYCLES_INT = (SAMPLE_DELAY_NS * CLK_MHZ) / 1000;
  localparam int CNT_WIDTH = 8;
  localparam logic [CNT_WIDTH-1:0] SAMPLE_CYCLES =
    SAMPLE_CYCLES_INT[CNT_WIDTH-1:0];
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE = 8'h01;
  // sequencer states
  typedef enum logic [1:0] {
    RTS_HELD,
    RTS_WAIT,
    RTS_DRIVE
  } rts_state_t;
endpackage

/* File: rtl/rts_seq_if.sv */
`timescale 1ns/1ps
// carries the sample-delay request between sequencer and timer
interface rts_seq_if;
  import rts_pkg::*;
  logic start;
  logic abort;
  logic done;
  logic busy;
  modport ctrl (output start, output abort, input done, input busy);
  modport timer (input start, input abort, output done, output busy);
endinterface

/* File: rtl/rts_sample_timer.sv */
`timescale 1ns/1ps
module rts_sample_timer
  import rts_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  rts_seq_if.timer seq
);
  logic [CNT_WIDTH-1:0] cnt;
  logic [CNT_WIDTH-1:0] next_cnt;
  logic run;
  logic next_run;

  ////////////////////////////////////////////////////////////////////////
  // down counter: done fires exactly SAMPLE_CYCLES after start
  always_comb begin
    next_cnt = cnt;
    next_run = run;
    if (seq.abort) begin
      // a reset assertion mid-count kills the pending sample
      next_run = 1'b0;
      next_cnt = CNT_ZERO;
    end else if (seq.start) begin
      next_run = 1'b1;
      next_cnt = SAMPLE_CYCLES - CNT_ONE;
    end else if (run) begin
      if (cnt == CNT_ZERO) begin
        next_run = 1'b0;
      end else begin
        next_cnt = cnt - CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= CNT_ZERO;
      run <= 1'b0;
    end else begin
      cnt <= next_cnt;
      run <= next_run;
    end
  end

  assign seq.done = run && (cnt == CNT_ZERO) && !seq.abort;
  assign seq.busy = run;
endmodule // rts_sample_timer

/* File: rtl/rts_top.sv */
`timescale 1ns/1ps
module rts_top
  import rts_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic POWER_ON_RESET_N,
  input wire logic SCAN_PORT_RESET_N,
  input wire logic [TP_WIDTH-1:0] TEST_POINT_PIN_I,
  output logic [TP_WIDTH-1:0] TEST_POINT_PIN_O,
  output logic [TP_WIDTH-1:0] TEST_POINT_PIN_OE_N,
  output logic [TP_WIDTH-1:0] TEST_POINT_PULLDOWN_EN,
  input wire logic [TP_WIDTH-1:0] TEST_OUT_DATA,
  output logic [TP_WIDTH-1:0] TEST_MODE_SEL,
  output logic TEST_MODE_VALID,
  output logic SELF_CONFIG_START,
  output logic SELF_CONFIG_ACTIVE,
  output logic SCAN_RESET_FAULT
);
  rts_seq_if seq ();

  rts_state_t state;
  rts_state_t next_state;
  logic por_q;
  logic por_rise;
  logic [TP_WIDTH-1:0] next_pin_o;
  logic [TP_WIDTH-1:0] next_oe_n;
  logic [TP_WIDTH-1:0] next_sel;
  logic next_valid;
  logic next_start;
  logic next_active;
  logic next_scan_fault;

  ////////////////////////////////////////////////////////////////////////
  // edge detect on the reset pin; pin taken as synchronous to REF_CLK
  assign por_rise = POWER_ON_RESET_N && !por_q;
  assign seq.start = por_rise && (state == RTS_HELD);
  assign seq.abort = !POWER_ON_RESET_N;

  rts_sample_timer u_timer (
    .clk(REF_CLK),
    .rst_n(NRST),
    .seq(seq)
  );

  // pulldowns stay enabled always, so a floating pin reads as normal mode
  assign TEST_POINT_PULLDOWN_EN = {TP_WIDTH{1'b1}};

  ////////////////////////////////////////////////////////////////////////
  // sequencer: held in reset, wait for sample point, then drive pins
  always_comb begin
    next_state = state;
    case (state)
      RTS_HELD: begin
        if (seq.start) begin
          next_state = RTS_WAIT;
        end
      end
      RTS_WAIT: begin
        if (!POWER_ON_RESET_N) begin
          next_state = RTS_HELD;
        end else if (seq.done) begin
          next_state = RTS_DRIVE;
        end
      end
      RTS_DRIVE: begin
        if (!POWER_ON_RESET_N) begin
          next_state = RTS_HELD;
        end
      end
      default: begin
        next_state = RTS_HELD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // output and strap values
  always_comb begin
    next_pin_o = TEST_POINT_PIN_O;
    next_oe_n = TEST_POINT_PIN_OE_N;
    next_sel = TEST_MODE_SEL;
    next_valid = TEST_MODE_VALID;
    next_start = 1'b0;
    next_active = SELF_CONFIG_ACTIVE;
    if (!POWER_ON_RESET_N) begin
      // everything inactive and pins floating while reset is held
      next_pin_o = TP_OUT_RST;
      next_oe_n = TP_OE_N_RST;
      next_sel = TEST_SEL_RST;
      next_valid = 1'b0;
      next_active = 1'b0;
    end else begin
      if (seq.start) begin
        next_start = 1'b1;
        next_active = 1'b1;
      end
      if (seq.done) begin
        // pins still floating here, so the straps are what we read
        next_sel = TEST_POINT_PIN_I;
        next_valid = 1'b1;
        next_oe_n = {TP_WIDTH{1'b0}};
        next_pin_o = TEST_OUT_DATA;
      end else if (state == RTS_DRIVE) begin
        next_pin_o = TEST_OUT_DATA;
      end
    end
  end

  // a high scan-port reset can upset startup; only flag it
  assign next_scan_fault = SCAN_PORT_RESET_N && POWER_ON_RESET_N;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      state <= RTS_HELD;
      por_q <= 1'b0;
      TEST_POINT_PIN_O <= TP_OUT_RST;
      TEST_POINT_PIN_OE_N <= TP_OE_N_RST;
      TEST_MODE_SEL <= TEST_SEL_RST;
      TEST_MODE_VALID <= 1'b0;
      SELF_CONFIG_START <= 1'b0;
      SELF_CONFIG_ACTIVE <= 1'b0;
      SCAN_RESET_FAULT <= 1'b0;
    end else begin
      state <= next_state;
      por_q <= POWER_ON_RESET_N;
      TEST_POINT_PIN_O <= next_pin_o;
      TEST_POINT_PIN_OE_N <= next_oe_n;
      TEST_MODE_SEL <= next_sel;
      TEST_MODE_VALID <= next_valid;
      SELF_CONFIG_START <= next_start;
      SELF_CONFIG_ACTIVE <= next_active;
      SCAN_RESET_FAULT <= next_scan_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  sequence s_release;
    seq.start ##1 POWER_ON_RESET_N [*8];
  endsequence

  a_held_quiet: assert property (
    !POWER_ON_RESET_N |=> !SELF_CONFIG_ACTIVE && !TEST_MODE_VALID
      && TEST_POINT_PIN_O == TP_OUT_RST)
    else $error("outputs active while reset held");

  a_held_float: assert property (
    !POWER_ON_RESET_N |=> TEST_POINT_PIN_OE_N == TP_OE_N_RST)
    else $error("test pins driven while reset held");

  a_edge_start: assert property (
    seq.start |=> SELF_CONFIG_START && SELF_CONFIG_ACTIVE ##1
      !SELF_CONFIG_START)
    else $error("release edge did not start configuration");

  a_no_early_drive: assert property (
    s_release |-> TEST_POINT_PIN_OE_N == TP_OE_N_RST)
    else $error("pins driven before sample point");

  ////////////////////////////////////////////////////////////////////////
  // checker helper: edges since the taken release edge, cleared while
  // reset is low; saturates so a long run never wraps onto the sample point
  logic [CNT_WIDTH-1:0] rel_cnt;
  logic [CNT_WIDTH-1:0] next_rel_cnt;

  always_comb begin
    next_rel_cnt = rel_cnt;
    if (!POWER_ON_RESET_N) begin
      next_rel_cnt = CNT_ZERO;
    end else if (seq.start) begin
      next_rel_cnt = CNT_ONE;
    end else if (rel_cnt != CNT_ZERO && rel_cnt != ~CNT_ZERO) begin
      next_rel_cnt = rel_cnt + CNT_ONE;
    end
  end

  // counter instead of a long repetition keeps the property cheap
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      rel_cnt <= CNT_ZERO;
    end else begin
      rel_cnt <= next_rel_cnt;
    end
  end

  // reset stayed released for the whole delay and the count is due now
  sequence s_sample_point;
    rel_cnt == SAMPLE_CYCLES && POWER_ON_RESET_N;
  endsequence

  a_sample_time: assert property (
    s_sample_point |=>
      TEST_MODE_VALID && TEST_POINT_PIN_OE_N == 8'h00)
    else $error("pins not sampled and driven at 1.5 us");

  a_wait_float: assert property (
    rel_cnt != CNT_ZERO && rel_cnt <= SAMPLE_CYCLES |->
      !TEST_MODE_VALID && TEST_POINT_PIN_OE_N == TP_OE_N_RST)
    else $error("pins driven or sampled during the delay");

  a_sample_value: assert property (
    seq.done |=> TEST_MODE_SEL == $past(TEST_POINT_PIN_I))
    else $error("selection differs from sampled pins");

  a_sel_hold: assert property (
    TEST_MODE_VALID && POWER_ON_RESET_N |=> $stable(TEST_MODE_SEL))
    else $error("selection changed without reset");

  a_sel_clear: assert property (
    !POWER_ON_RESET_N |=> TEST_MODE_SEL == TEST_SEL_RST)
    else $error("selection not cleared by reset");

  a_pulldown_on: assert property (
    TEST_POINT_PULLDOWN_EN == 8'hff)
    else $error("pulldown disabled");
endmodule // rts_top

/* File: sim/rts_pmic_model.sv */
`timescale 1ns/1ps
module rts_pmic_model
  import rts_pkg::*;
(
  input wire logic clk,
  input wire logic stable,
  input wire logic [TP_WIDTH-1:0] strap,
  input wire logic [TP_WIDTH-1:0] pin_o,
  input wire logic [TP_WIDTH-1:0] oe_n,
  input wire logic [TP_WIDTH-1:0] pd_en,
  output logic por_n,
  output logic [TP_WIDTH-1:0] pin_i
);
  // reset follows supply state a cycle late, never early
  always @(posedge clk) begin
    por_n <= stable;
  end
  // driver wins; strap pullup only pulls while pin floats
  always_comb begin
    for (int i = 0; i < TP_WIDTH; i++) begin
      pin_i[i] = !oe_n[i] ? pin_o[i] : (strap[i] | !pd_en[i]);
    end
  end
endmodule // rts_pmic_model

/* File: sim/reset_test_strap_sampler_test.sv */
`timescale 1ns/1ps
module reset_test_strap_sampler_test;
  import rts_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic stable = 1'b0;
  logic scan_n = 1'b0;
  logic [7:0] strap = 8'h00;
  logic [7:0] data = 8'h00;
  logic por_n;
  logic [7:0] pin_i, pin_o, oe_n, pd_en, sel;
  logic valid, start, active, fault;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  rts_top i_rts_top (.REF_CLK(ref_clk), .NRST(nrst),
    .POWER_ON_RESET_N(por_n), .SCAN_PORT_RESET_N(scan_n),
    .TEST_POINT_PIN_I(pin_i), .TEST_POINT_PIN_O(pin_o),
    .TEST_POINT_PIN_OE_N(oe_n), .TEST_POINT_PULLDOWN_EN(pd_en),
    .TEST_OUT_DATA(data), .TEST_MODE_SEL(sel), .TEST_MODE_VALID(valid),
    .SELF_CONFIG_START(start), .SELF_CONFIG_ACTIVE(active),
    .SCAN_RESET_FAULT(fault));
  rts_pmic_model i_rts_pmic_model (.clk(ref_clk), .stable(stable),
    .strap(strap), .pin_o(pin_o), .oe_n(oe_n), .pd_en(pd_en),
    .por_n(por_n), .pin_i(pin_i));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ceiling well above the two sampling runs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // supplies drop: everything must go quiet and the pins float
  task check_held;
    stable = 1'b0;
    strap = 8'h5a;
    repeat (3) @(negedge ref_clk);
    chk(oe_n, 8'hff, "pins not floating");
    chk(pin_o, 8'h00, "pin drive active");
    chk({6'h00, valid, active}, 8'h00, "flags active");
    chk(sel, 8'h00, "selection kept");
    chk({7'h00, start}, 8'h00, "start while held");
    chk(pd_en, 8'hff, "pulldowns off");
  endtask
  // release, then strap sampled 150 cycles after the taken edge
  task release_and_sample(input logic [7:0] s, input logic [7:0] d);
    strap = s;
    data = d;
    stable = 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({6'h00, start, active}, 8'h03, "no start pulse");
    repeat (149) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({7'h00, valid}, 8'h00, "sampled early");
    chk(oe_n, 8'hff, "driven early");
    @(negedge ref_clk);
    chk({6'h00, valid, start}, 8'h02, "not sampled");
    chk(sel, s, "wrong selection");
    chk(oe_n, 8'h00, "pins not driven");
    chk(pin_o, d, "wrong drive");
    data = ~d;
    strap = ~s;
    @(negedge ref_clk);
    chk(pin_o, ~d, "drive not following");
    repeat (4) @(negedge ref_clk);
    chk(sel, s, "selection changed");
  endtask
  // scan reset left high while running raises the fault flag
  task scan_fault;
    scan_n = 1'b1;
    @(negedge ref_clk);
    chk({7'h00, fault}, 8'h01, "no scan fault");
    scan_n = 1'b0;
    @(negedge ref_clk);
    chk({7'h00, fault}, 8'h00, "fault stuck");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    check_held();
    release_and_sample(8'h00, 8'h3c);
    scan_fault();
    check_held();
    release_and_sample(8'ha5, 8'hc3);
    tally_and_finish();
  end
endmodule // reset_test_strap_sampler_test
